// ---- hdl/dwi_dual_dac_if.sv ----
/*
  Digital input logic of a dual 12-bit DAC, built in one of three host
  interface variants: serial shift, byte-wide double buffered, or 12-bit
  parallel edge loaded. Holds the DAC registers, plus input registers in the serial and byte-wide variants, and presents the
  two DAC words.
  Assumes every host pin is asynchronous to CLK_IN and changes slowly
  enough (edges at least three CLK_IN periods apart) to be seen through a
  two-stage synchroniser; the clear pin additionally acts asynchronously.
*/
// Behaviour
// - clear low zeroes the serial and byte-wide input and DAC registers asynchronously
// - serial falling clock shifts, data enters bit 23
// - strobe A alone loads bits 23..12 into A
// - strobe B alone loads bits 11..0 into B
// - both strobes load both channels together
// - shift register moves on serial falling edge only
// - address 00 loads channel A low byte
// - address 01 loads channel A high nibble
// - address 10 loads channel B low byte
// - address 11 loads channel B high nibble
// - transfer with select high updates both DACs
// - transfer with select low makes DACs transparent
// - select rising edge with write low loads channel
// - write edge with select A loads A
// - write edge with select B loads B
// - write edge with both selects loads both
`timescale 1ns/1ps
`default_nettype none

module dwi_dual_dac_if
  import dwi_pkg::*;
#(
  parameter dwi_pkg::dwi_variant_e VARIANT = dwi_pkg::DWI_SERIAL
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        SERIAL_CLK_IN,
  input  wire logic        SERIAL_DATA_IN,
  input  wire logic        CHIP_SELECT_N_IN,
  input  wire logic        LOAD_STROBE_CHAN_A_N_IN,
  input  wire logic        LOAD_STROBE_CHAN_B_N_IN,
  input  wire logic        CLEAR_ALL_N_IN,
  input  wire logic        TRANSFER_STROBE_N_IN,
  input  wire logic        WRITE_N_IN,
  input  wire logic        REG_ADDR_HI_IN,
  input  wire logic        REG_ADDR_LO_IN,
  input  wire logic        SELECT_CHAN_A_N_IN,
  input  wire logic        SELECT_CHAN_B_N_IN,
  input  wire logic [11:0] BUS_LINE_IN,
  output logic      [11:0] DAC_A_OUT,
  output logic      [11:0] DAC_B_OUT
);
  import dwi_pkg::*;

  dwi_pins_s   pins_raw;
  dwi_pins_s   meta_r;
  dwi_pins_s   cur_r;
  dwi_pins_s   prev_r;
  logic [11:0] dac_a_r;
  logic [11:0] dac_b_r;
  logic        clr_async_n;

  function automatic logic [11:0] rev12(input logic [11:0] v);
    logic [11:0] r;
    r = '0;
    for (int i = 0; i < 12; i++) begin
      r[11 - i] = v[i];
    end
    return r;
  endfunction : rev12

  always_comb begin
    pins_raw.serial_clk           = SERIAL_CLK_IN;
    pins_raw.serial_data          = SERIAL_DATA_IN;
    pins_raw.chip_select_n        = CHIP_SELECT_N_IN;
    pins_raw.load_strobe_chan_a_n = LOAD_STROBE_CHAN_A_N_IN;
    pins_raw.load_strobe_chan_b_n = LOAD_STROBE_CHAN_B_N_IN;
    pins_raw.clear_all_n          = CLEAR_ALL_N_IN;
    pins_raw.transfer_strobe_n    = TRANSFER_STROBE_N_IN;
    pins_raw.write_n              = WRITE_N_IN;
    pins_raw.reg_addr_hi          = REG_ADDR_HI_IN;
    pins_raw.reg_addr_lo          = REG_ADDR_LO_IN;
    pins_raw.select_chan_a_n      = SELECT_CHAN_A_N_IN;
    pins_raw.select_chan_b_n      = SELECT_CHAN_B_N_IN;
    pins_raw.bus_line             = BUS_LINE_IN;
  end

  // two-stage synchroniser; prev_r is one more stage kept for edge finding
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      meta_r <= '1;
      cur_r  <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= pins_raw;
      cur_r  <= meta_r;
      prev_r <= cur_r;
    end
  end

  // the parallel variant has no clear pin; its registers ignore it
  assign clr_async_n = (VARIANT == DWI_PARALLEL) ? 1'b1 : CLEAR_ALL_N_IN;

  assign DAC_A_OUT = dac_a_r;
  assign DAC_B_OUT = dac_b_r;

  if (VARIANT == DWI_SERIAL) begin : g_serial
    logic [23:0] shift_r;
    logic        sclk_fall;
    logic        active;

    assign sclk_fall = prev_r.serial_clk && !cur_r.serial_clk;
    // the synced clear also gates, so loads resume only after its release
    assign active    = !cur_r.chip_select_n && cur_r.clear_all_n;

    always_ff @(posedge CLK_IN or negedge RST_N_IN or negedge clr_async_n) begin
      if (!RST_N_IN || !clr_async_n) begin
        shift_r <= DWI_SHIFT_RST;
      end else if (active && sclk_fall) begin
        shift_r <= {cur_r.serial_data, shift_r[23:1]};
      end
    end

    // strobes are level sensitive: the DAC follows the shift register while held
    always_ff @(posedge CLK_IN or negedge RST_N_IN or negedge clr_async_n) begin
      if (!RST_N_IN || !clr_async_n) begin
        dac_a_r <= DWI_DAC_RST;
        dac_b_r <= DWI_DAC_RST;
      end else begin
        if (active && !cur_r.load_strobe_chan_a_n) begin
          dac_a_r <= rev12(shift_r[DWI_FIELD_A_LO +: DWI_WORD_W]);
        end
        if (active && !cur_r.load_strobe_chan_b_n) begin
          dac_b_r <= rev12(shift_r[DWI_FIELD_B_LO +: DWI_WORD_W]);
        end
      end
    end

    clear_zeroes_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      (!CLEAR_ALL_N_IN)[*2] |-> (dac_a_r == 12'h000 && dac_b_r == 12'h000 && shift_r == 24'h000000))
      else $error("clear did not zero the serial registers");
    shift_entry_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      active && sclk_fall |=> shift_r == {$past(cur_r.serial_data), $past(shift_r[23:1])})
      else $error("serial shift did not enter at bit 23");
    load_a_only_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      active && !cur_r.load_strobe_chan_a_n && cur_r.load_strobe_chan_b_n
      |=> dac_a_r == rev12($past(shift_r[23:12])) && $stable(dac_b_r))
      else $error("channel A load from shift register wrong");
    load_b_only_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      active && cur_r.load_strobe_chan_a_n && !cur_r.load_strobe_chan_b_n
      |=> dac_b_r == rev12($past(shift_r[11:0])) && $stable(dac_a_r))
      else $error("channel B load from shift register wrong");
    load_both_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      active && !cur_r.load_strobe_chan_a_n && !cur_r.load_strobe_chan_b_n
      |=> dac_a_r == rev12($past(shift_r[23:12])) && dac_b_r == rev12($past(shift_r[11:0])))
      else $error("simultaneous load of both channels wrong");
    shift_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      !(active && sclk_fall) |=> $stable(shift_r))
      else $error("shift register moved without a falling serial clock");
    // named steps of a serial transfer; strobes are level, so loads repeat while held
    sequence s_ser_idle;
      !active;
    endsequence
    sequence s_ser_load_a;
      active && !cur_r.load_strobe_chan_a_n;
    endsequence
    sequence s_ser_load_b;
      active && !cur_r.load_strobe_chan_b_n;
    endsequence
    sequence s_ser_cleared;
      !cur_r.clear_all_n;
    endsequence
    deselect_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_ser_idle |=> $stable(shift_r) && $stable(dac_a_r) && $stable(dac_b_r))
      else $error("serial registers changed while deselected");
    strobe_a_track_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_ser_load_a ##1 s_ser_load_a |=> dac_a_r == rev12($past(shift_r[23:12])))
      else $error("channel A did not follow the shift register");
    strobe_b_track_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_ser_load_b ##1 s_ser_load_b |=> dac_b_r == rev12($past(shift_r[11:0])))
      else $error("channel B did not follow the shift register");
    clear_gate_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_ser_cleared |=> $stable(shift_r) && $stable(dac_a_r))
      else $error("serial registers moved before clear release was seen");
  end else if (VARIANT == DWI_BYTEWIDE) begin : g_bytewide
    logic [7:0] a_lo_r;
    logic [3:0] a_hi_r;
    logic [7:0] b_lo_r;
    logic [3:0] b_hi_r;
    logic [1:0] addr;
    logic       in_load;
    logic       dac_load;

    assign addr     = {cur_r.reg_addr_hi, cur_r.reg_addr_lo};
    // select and write low load input registers whatever the transfer strobe
    assign in_load  = cur_r.clear_all_n && !cur_r.chip_select_n && !cur_r.write_n;
    assign dac_load = cur_r.clear_all_n && !cur_r.transfer_strobe_n && !cur_r.write_n;

    always_ff @(posedge CLK_IN or negedge RST_N_IN or negedge clr_async_n) begin
      if (!RST_N_IN || !clr_async_n) begin
        a_lo_r <= DWI_LO_RST;
        a_hi_r <= DWI_HI_RST;
        b_lo_r <= DWI_LO_RST;
        b_hi_r <= DWI_HI_RST;
      end else if (in_load) begin
        unique case (addr)
          DWI_ADDR_A_LO: a_lo_r <= cur_r.bus_line[7:0];
          DWI_ADDR_A_HI: a_hi_r <= cur_r.bus_line[3:0];
          DWI_ADDR_B_LO: b_lo_r <= cur_r.bus_line[7:0];
          DWI_ADDR_B_HI: b_hi_r <= cur_r.bus_line[3:0];
        endcase
      end
    end

    // with select also low the DACs track the input registers one cycle behind
    always_ff @(posedge CLK_IN or negedge RST_N_IN or negedge clr_async_n) begin
      if (!RST_N_IN || !clr_async_n) begin
        dac_a_r <= DWI_DAC_RST;
        dac_b_r <= DWI_DAC_RST;
      end else if (dac_load) begin
        dac_a_r <= {a_hi_r, a_lo_r};
        dac_b_r <= {b_hi_r, b_lo_r};
      end
    end

    byte_clear_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      (!CLEAR_ALL_N_IN)[*2] |-> ({a_lo_r, a_hi_r, b_lo_r, b_hi_r} == 24'h000000 && dac_a_r == 12'h000))
      else $error("clear did not zero the byte-wide registers");
    a_low_load_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      in_load && addr == DWI_ADDR_A_LO |=> a_lo_r == $past(cur_r.bus_line[7:0]) && $stable(b_lo_r))
      else $error("channel A low byte not loaded");
    a_high_load_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      in_load && addr == DWI_ADDR_A_HI |=> a_hi_r == $past(cur_r.bus_line[3:0]) && $stable(a_lo_r))
      else $error("channel A high nibble not loaded");
    b_low_load_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      in_load && addr == DWI_ADDR_B_LO |=> b_lo_r == $past(cur_r.bus_line[7:0]) && $stable(a_lo_r))
      else $error("channel B low byte not loaded");
    b_high_load_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      in_load && addr == DWI_ADDR_B_HI |=> b_hi_r == $past(cur_r.bus_line[3:0]) && $stable(b_lo_r))
      else $error("channel B high nibble not loaded");
    no_write_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      cur_r.write_n |=> $stable({a_lo_r, a_hi_r, b_lo_r, b_hi_r}) && $stable(dac_a_r))
      else $error("registers changed with write high");
    transfer_both_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      dac_load && cur_r.chip_select_n |=> dac_a_r == $past({a_hi_r, a_lo_r}) && dac_b_r == $past({b_hi_r, b_lo_r}))
      else $error("transfer did not update both DAC registers");
    sequence s_transparent_write;
      dac_load && !cur_r.chip_select_n && addr == DWI_ADDR_A_LO;
    endsequence
    transparent_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_transparent_write ##1 dac_load |=> dac_a_r[7:0] == $past(cur_r.bus_line[7:0], 2))
      else $error("transparent mode did not pass the written byte");
    // refusal and transfer steps; the transfer must never touch the input registers
    sequence s_byte_refused;
      cur_r.write_n || (cur_r.chip_select_n && cur_r.transfer_strobe_n);
    endsequence
    sequence s_byte_transfer;
      dac_load && cur_r.chip_select_n;
    endsequence
    sequence s_transparent_b;
      dac_load && !cur_r.chip_select_n && addr == DWI_ADDR_B_LO;
    endsequence
    refused_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_byte_refused |=> $stable({a_lo_r, a_hi_r, b_lo_r, b_hi_r}) && $stable(dac_a_r) && $stable(dac_b_r))
      else $error("byte-wide registers changed on a refused cycle");
    transfer_inputs_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_byte_transfer |=> $stable({a_lo_r, a_hi_r, b_lo_r, b_hi_r}))
      else $error("transfer disturbed the input registers");
    transparent_b_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      s_transparent_b ##1 dac_load |=> dac_b_r[7:0] == $past(cur_r.bus_line[7:0], 2))
      else $error("transparent mode did not pass the channel B byte");
    byte_clear_gate_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN || !clr_async_n)
      !cur_r.clear_all_n |=> $stable({a_lo_r, a_hi_r, b_lo_r, b_hi_r}) && $stable(dac_a_r))
      else $error("byte-wide registers moved before clear release was seen");
  end else begin : g_parallel
    logic sel_a_rise;
    logic sel_b_rise;
    logic wr_rise;
    logic load_a;
    logic load_b;

    assign sel_a_rise = !prev_r.select_chan_a_n && cur_r.select_chan_a_n;
    assign sel_b_rise = !prev_r.select_chan_b_n && cur_r.select_chan_b_n;
    assign wr_rise    = !prev_r.write_n && cur_r.write_n;
    // bus and the non-edge pin (write or select) are taken from the cycle before the edge
    assign load_a = (sel_a_rise && !prev_r.write_n) || (wr_rise && !prev_r.select_chan_a_n);
    assign load_b = (sel_b_rise && !prev_r.write_n) || (wr_rise && !prev_r.select_chan_b_n);

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
        dac_a_r <= DWI_DAC_RST;
        dac_b_r <= DWI_DAC_RST;
      end else begin
        if (load_a) begin
          dac_a_r <= prev_r.bus_line;
        end
        if (load_b) begin
          dac_b_r <= prev_r.bus_line;
        end
      end
    end

    select_edge_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      sel_a_rise && !prev_r.write_n |=> dac_a_r == $past(prev_r.bus_line))
      else $error("select rising edge did not load channel A");
    idle_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      !wr_rise && !sel_a_rise && !sel_b_rise |=> $stable(dac_a_r) && $stable(dac_b_r))
      else $error("DAC register changed without a load edge");
    write_a_only_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      wr_rise && !prev_r.select_chan_a_n && prev_r.select_chan_b_n && !sel_b_rise
      |=> dac_a_r == $past(prev_r.bus_line) && $stable(dac_b_r))
      else $error("write edge did not load channel A alone");
    write_b_only_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      wr_rise && prev_r.select_chan_a_n && !prev_r.select_chan_b_n && !sel_a_rise
      |=> dac_b_r == $past(prev_r.bus_line) && $stable(dac_a_r))
      else $error("write edge did not load channel B alone");
    write_both_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      wr_rise && !prev_r.select_chan_a_n && !prev_r.select_chan_b_n
      |=> dac_a_r == dac_b_r && dac_a_r == $past(prev_r.bus_line))
      else $error("write edge did not load both channels");
    write_fall_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      prev_r.write_n && !cur_r.write_n && !sel_a_rise && !sel_b_rise |=> $stable(dac_a_r) && $stable(dac_b_r))
      else $error("falling write edge loaded a DAC register");
    // both selects high on both stages means no select edge can be in flight
    sequence s_sel_b_load;
      sel_b_rise && !prev_r.write_n;
    endsequence
    sequence s_deselected;
      prev_r.select_chan_a_n && prev_r.select_chan_b_n && cur_r.select_chan_a_n && cur_r.select_chan_b_n;
    endsequence
    select_edge_b_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      s_sel_b_load |=> dac_b_r == $past(prev_r.bus_line))
      else $error("select rising edge did not load channel B");
    par_deselect_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      s_deselected |=> $stable(dac_a_r) && $stable(dac_b_r))
      else $error("DAC register changed with both selects high");
    write_high_hold_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      prev_r.write_n && cur_r.write_n |=> $stable(dac_a_r) && $stable(dac_b_r))
      else $error("DAC register changed with write held high");
  end

endmodule : dwi_dual_dac_if

`default_nettype wire

// ---- hdl/dwi_pkg.sv ----
/*
  Shared constants and types for the dual DAC digital input logic:
  variant selection, word widths, shift-register field positions and the
  packed bundle that carries the host pins into the block.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package dwi_pkg;

  localparam int unsigned DWI_WORD_W   = 12;
  localparam int unsigned DWI_SHIFT_W  = 24;
  localparam int unsigned DWI_LO_W     = 8;
  localparam int unsigned DWI_HI_W     = 4;
  localparam int unsigned DWI_SYNC_DEPTH = 2;

  // serial shift register: entry position and the two channel fields
  localparam int unsigned DWI_SHIFT_ENTRY = 23;
  localparam int unsigned DWI_FIELD_A_LO  = 12;
  localparam int unsigned DWI_FIELD_B_LO  = 0;

  // register reset value, also the value forced by the clear pin
  localparam logic [11:0] DWI_DAC_RST   = 12'h000;
  localparam logic [23:0] DWI_SHIFT_RST = 24'h000000;
  localparam logic [7:0]  DWI_LO_RST    = 8'h00;
  localparam logic [3:0]  DWI_HI_RST    = 4'h0;

  // byte-wide address codes {reg_addr_hi, reg_addr_lo}
  localparam logic [1:0] DWI_ADDR_A_LO = 2'h0;
  localparam logic [1:0] DWI_ADDR_A_HI = 2'h1;
  localparam logic [1:0] DWI_ADDR_B_LO = 2'h2;
  localparam logic [1:0] DWI_ADDR_B_HI = 2'h3;

  typedef enum logic [1:0] {
    DWI_SERIAL   = 2'b00,
    DWI_BYTEWIDE = 2'b01,
    DWI_PARALLEL = 2'b10
  } dwi_variant_e;

  typedef struct packed {
    logic        serial_clk;
    logic        serial_data;
    logic        chip_select_n;
    logic        load_strobe_chan_a_n;
    logic        load_strobe_chan_b_n;
    logic        clear_all_n;
    logic        transfer_strobe_n;
    logic        write_n;
    logic        reg_addr_hi;
    logic        reg_addr_lo;
    logic        select_chan_a_n;
    logic        select_chan_b_n;
    logic [11:0] bus_line;
  } dwi_pins_s;

endpackage : dwi_pkg

// ---- testbench/dwi_dual_dac_if_tb_top.sv ----
/*
  self-checking bench: one instance of each variant shares the host pins;
  the host model drives them and each scenario checks only its own variant.
  assumes pins idle high, so idle variants see no transfer.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module dwi_dual_dac_if_tb_top;
  import dwi_pkg::*;

  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  dwi_pins_s          pins;
  logic        [11:0] dac_a [3];
  logic        [11:0] dac_b [3];
  int                 bad_count = 0;
  int                 samples_checked = 0;
  int                 cyc = 0;

  always #4 clk = ~clk;

  dwi_host_model u_dwi_host_model (.clk_in(clk), .pins_out(pins));

  for (genvar v = 0; v < 3; v++) begin : g_var
    dwi_dual_dac_if #(.VARIANT(dwi_variant_e'(v))) u_dwi_dual_dac_if (
      .CLK_IN(clk), .RST_N_IN(rst_n), .SERIAL_CLK_IN(pins.serial_clk), .SERIAL_DATA_IN(pins.serial_data),
      .CHIP_SELECT_N_IN(pins.chip_select_n), .LOAD_STROBE_CHAN_A_N_IN(pins.load_strobe_chan_a_n),
      .LOAD_STROBE_CHAN_B_N_IN(pins.load_strobe_chan_b_n), .CLEAR_ALL_N_IN(pins.clear_all_n),
      .TRANSFER_STROBE_N_IN(pins.transfer_strobe_n), .WRITE_N_IN(pins.write_n),
      .REG_ADDR_HI_IN(pins.reg_addr_hi), .REG_ADDR_LO_IN(pins.reg_addr_lo),
      .SELECT_CHAN_A_N_IN(pins.select_chan_a_n), .SELECT_CHAN_B_N_IN(pins.select_chan_b_n),
      .BUS_LINE_IN(pins.bus_line), .DAC_A_OUT(dac_a[v]), .DAC_B_OUT(dac_b[v]));
  end

  function automatic logic [11:0] word_of(input logic [3:0] nib, input logic [7:0] lo);
    return {nib, lo};
  endfunction : word_of

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // whole run needs about 1700 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic pulse_clear(input int v);
    u_dwi_host_model.set_clear(1'b0);
    #1;
    `CHK(dac_a[v], DWI_DAC_RST)
    `CHK(dac_b[v], DWI_DAC_RST)
    u_dwi_host_model.idle(3);
    u_dwi_host_model.set_clear(1'b1);
    u_dwi_host_model.idle(4);
  endtask : pulse_clear

  initial begin
    logic [11:0] a1, b1, a2, b2, wa, wb, w, ea, eb;
    logic [2:0]  par_tab [5];
    par_tab = '{3'b011, 3'b100, 3'b010, 3'b000, 3'b110};
    void'($urandom(32'hb520));
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    u_dwi_host_model.idle(3);
    a1 = 12'($urandom);
    b1 = 12'($urandom);
    a2 = ~a1;
    b2 = ~b1;
    u_dwi_host_model.ser_frame(b1, a1, 1'b0);
    u_dwi_host_model.ser_strobe(1'b0, 1'b1);
    `CHK(dac_a[0], a1)
    `CHK(dac_b[0], DWI_DAC_RST)
    u_dwi_host_model.ser_frame(b2, a2, 1'b1);
    u_dwi_host_model.ser_strobe(1'b1, 1'b0);
    `CHK(dac_b[0], b1)
    `CHK(dac_a[0], a1)
    u_dwi_host_model.ser_frame(12'h801, 12'hffe, 1'b0);
    u_dwi_host_model.ser_strobe(1'b0, 1'b0);
    `CHK(dac_a[0], 12'hffe)
    `CHK(dac_b[0], 12'h801)
    pulse_clear(0);
    u_dwi_host_model.ser_strobe(1'b0, 1'b0);
    `CHK(dac_a[0], DWI_DAC_RST)
    `CHK(dac_b[0], DWI_DAC_RST)
    wa = 12'($urandom);
    wb = 12'($urandom);
    u_dwi_host_model.byte_op(DWI_ADDR_A_LO, wa[7:0], 1'b0, 1'b1);
    u_dwi_host_model.byte_op(DWI_ADDR_A_HI, {4'($urandom), wa[11:8]}, 1'b0, 1'b1);
    u_dwi_host_model.byte_op(DWI_ADDR_B_LO, wb[7:0], 1'b0, 1'b1);
    u_dwi_host_model.byte_op(DWI_ADDR_B_HI, {4'($urandom), wb[11:8]}, 1'b0, 1'b1);
    `CHK(dac_a[1], DWI_DAC_RST)
    u_dwi_host_model.byte_op(DWI_ADDR_A_LO, 8'h00, 1'b1, 1'b0);
    `CHK(dac_a[1], word_of(wa[11:8], wa[7:0]))
    `CHK(dac_b[1], word_of(wb[11:8], wb[7:0]))
    u_dwi_host_model.byte_op(DWI_ADDR_B_LO, 8'h5a, 1'b0, 1'b0);
    `CHK(dac_b[1], word_of(wb[11:8], 8'h5a))
    `CHK(dac_a[1], wa)
    pulse_clear(1);
    u_dwi_host_model.byte_op(DWI_ADDR_A_LO, 8'h00, 1'b1, 1'b0);
    `CHK(dac_b[1], DWI_DAC_RST)
    ea = DWI_DAC_RST;
    eb = DWI_DAC_RST;
    foreach (par_tab[i]) begin
      w = 12'($urandom);
      u_dwi_host_model.par_op(par_tab[i][2], par_tab[i][1], w, par_tab[i][0]);
      if (!par_tab[i][2]) ea = w;
      if (!par_tab[i][1]) eb = w;
      `CHK(dac_a[2], ea)
      `CHK(dac_b[2], eb)
    end
    final_report();
  end

endmodule : dwi_dual_dac_if_tb_top

`default_nettype wire

// ---- testbench/dwi_host_model.sv ----
/*
  host side model for the dual dac digital input logic: drives every pin of
  all three variants, changing them only at falling CLK_IN edges.
  assumes the design samples pins through a synchroniser and needs each level
  held three cycles or more; the serial clock idles high between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module dwi_host_model (
  input  wire logic          clk_in,
  output var  dwi_pkg::dwi_pins_s pins_out
);
  import dwi_pkg::*;

  initial pins_out = '1;

  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : idle

  task automatic set_clear(input logic v);
    pins_out.clear_all_n = v;
  endtask : set_clear

  // one serial bit every 160 ns; b word goes first, msb first
  task automatic ser_frame(input logic [11:0] b, input logic [11:0] a, input logic cs_n);
    logic [23:0] w;
    w = {b, a};
    pins_out.chip_select_n = cs_n;
    idle(4);
    for (int i = 23; i >= 0; i--) begin
      pins_out.serial_data = w[i];
      pins_out.serial_clk  = 1'b1;
      idle(10);
      pins_out.serial_clk  = 1'b0;
      idle(10);
    end
    pins_out.serial_clk  = 1'b1;
    // data no longer valid: show the inverse so a late sample cannot match by luck
    pins_out.serial_data = ~w[0];
  endtask : ser_frame

  task automatic ser_strobe(input logic a_n, input logic b_n);
    pins_out.chip_select_n = 1'b0;
    idle(4);
    pins_out.load_strobe_chan_a_n = a_n;
    pins_out.load_strobe_chan_b_n = b_n;
    idle(6);
    pins_out.load_strobe_chan_a_n = 1'b1;
    pins_out.load_strobe_chan_b_n = 1'b1;
    idle(4);
    pins_out.chip_select_n = 1'b1;
    idle(4);
  endtask : ser_strobe

  // high lines carry junk on nibble writes to show they are ignored
  task automatic byte_op(input logic [1:0] addr, input logic [7:0] d, input logic cs_n, input logic xfer_n);
    {pins_out.reg_addr_hi, pins_out.reg_addr_lo} = addr;
    pins_out.bus_line          = {~d[3:0], d};
    pins_out.chip_select_n     = cs_n;
    pins_out.transfer_strobe_n = xfer_n;
    pins_out.write_n           = 1'b0;
    idle(6);
    pins_out.write_n           = 1'b1;
    pins_out.transfer_strobe_n = 1'b1;
    pins_out.chip_select_n     = 1'b1;
    pins_out.bus_line          = ~pins_out.bus_line;
    idle(4);
  endtask : byte_op

  // by_sel: load on select rising edge with write low, else on write rising edge
  task automatic par_op(input logic sa_n, input logic sb_n, input logic [11:0] w, input logic by_sel);
    pins_out.bus_line = w;
    pins_out.write_n  = ~by_sel;
    idle(4);
    pins_out.select_chan_a_n = sa_n;
    pins_out.select_chan_b_n = sb_n;
    pins_out.write_n         = 1'b0;
    idle(4);
    if (by_sel) begin
      pins_out.select_chan_a_n = 1'b1;
      pins_out.select_chan_b_n = 1'b1;
    end else begin
      pins_out.write_n = 1'b1;
    end
    idle(4);
    pins_out.select_chan_a_n = 1'b1;
    pins_out.select_chan_b_n = 1'b1;
    pins_out.write_n         = 1'b1;
    pins_out.bus_line        = ~w;
    idle(4);
  endtask : par_op

endmodule : dwi_host_model

`default_nettype wire
